//--- dv/thru_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// instruction sequencer stand-in: clear and halt pulses, reg bus
// ----------------------------------------------------------------
module thru_core_model (
  input  wire logic                       clk,
  input  wire logic [7:0]                 regRdData,
  output logic      [3:0]                 exec,
  output logic                            regWrEn,
  output logic      [7:0]                 regAddr,
  output logic      [7:0]                 regWrData,
  output logic      [thru_pkg::IRQ_N-1:0] irqFlags,
  output logic      [thru_pkg::IRQ_N-1:0] irqEnable,
  output logic                            stackFull
);
  initial begin
    exec      = 4'h0;
    regWrEn   = 1'b0;
    regAddr   = thru_pkg::REALTIME_TICK_CONTROL_ADDR;
    regWrData = 8'h00;
    irqFlags  = '0;
    irqEnable = '1;
    stackFull = 1'b0;
  end

  // exec index: 0 single clear, 1 first, 2 second, 3 power-down
  task pulse(input int i);
    @(posedge clk);
    exec[i] <= 1'b1;
    @(posedge clk);
    exec[i] <= 1'b0;
  endtask : pulse

  task writeReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrEn   <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn   <= 1'b0;
  endtask : writeReg

  // read data is registered, so it lands one edge after the address
  task readReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    @(posedge clk);
    #1;
    d = regRdData;
  endtask : readReg

  // software only picks the four longer tick periods
  task setTick(input logic [1:0] c);
    writeReg(thru_pkg::REALTIME_TICK_CONTROL_ADDR, {5'h00, 1'b1, c});
  endtask : setTick
endmodule : thru_core_model

//--- dv/thru_core_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin \
  errTotal++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module thru_core_test;
  logic       clk, arst_n, chipInitPin_n, optDogEnable, optDualClear;
  logic       dogOscTick, rtcOscTick;
  logic [1:0] optClkSrc, optTbSel;
  logic [2:0] optLcdSel, optBuzzSel;
  logic [7:0] optWakeEn, portA, rd;
  wire logic [3:0] exec, irqFlags, irqEnable;
  wire logic [7:0] regAddr, regWrData, regRdData;
  wire logic  regWrEn, stackFull, chipResetOut, warmResetOut, timeoutFlag;
  wire logic  powerdownFlag, sysOscRun, coreStalled, resumeGo, wakeVector;
  wire logic  periodicTickPulse, realtimeTickPulse, timerRtcTick;
  wire logic  lcdClkTick, buzzClkTick;
  wire logic [6:0] obs = {resumeGo, warmResetOut, chipResetOut, buzzClkTick,
                          lcdClkTick, periodicTickPulse, realtimeTickPulse};
  int errTotal, nCompared, cyc, n;

  thru_core thru_core_inst (.clk, .arst_n, .chipInitPin_n,
    .execDogClearSingle(exec[0]), .execDogClearFirst(exec[1]),
    .execDogClearSecond(exec[2]), .execPowerDown(exec[3]), .optDogEnable,
    .optDualClear, .optClkSrc, .optLcdSel, .optBuzzSel, .optTbSel,
    .optWakeEn, .dogOscTick, .rtcOscTick, .portA, .irqFlags, .irqEnable,
    .stackFull, .regWrEn, .regAddr, .regWrData, .regRdData, .chipResetOut,
    .warmResetOut, .timeoutFlag, .powerdownFlag, .sysOscRun, .coreStalled,
    .resumeGo, .wakeVector, .periodicTickPulse, .realtimeTickPulse,
    .timerRtcTick, .lcdClkTick, .buzzClkTick);
  thru_core_model thru_core_model_inst (.clk, .regRdData, .exec, .regWrEn,
    .regAddr, .regWrData, .irqFlags, .irqEnable, .stackFull);

  // ----------------------------------------------------------------
  // clock, watchdog of the run, helpers
  // ----------------------------------------------------------------
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    rtcOscTick <= ~rtcOscTick;
    if (cyc == 200000) begin
      errTotal++;
      endSim();
    end
  end

  task endSim();
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : endSim

  // obs: 0 rt, 1 tb, 2 lcd, 3 buzz, 4 chip rst, 5 warm rst, 6 resume
  task waitFor(input int i, input int lim, output int k);
    k = 0;
    do begin @(posedge clk); #1; k++; end while (obs[i] !== 1'b1 && k < lim);
  endtask : waitFor

  task period(input int i, input int p);
    waitFor(i, 40000, n);
    waitFor(i, 40000, n);
    `CHK("tap period", p, n);
  endtask : period

  task enterHalt();
    thru_core_model_inst.pulse(3);
    #1;
    `CHK("pdf at halt", 1'b1, powerdownFlag);
    `CHK("to at halt", 1'b0, timeoutFlag);
    `CHK("osc at halt", 1'b0, sysOscRun);
  endtask : enterHalt

  task waitResume(input logic vec);
    waitFor(6, 1100, n);
    `CHK("startup", 1'b1, n >= 1024 && n <= 1030);
    `CHK("vector", vec, wakeVector);
  endtask : waitResume

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task tRegs();
    `CHK("flags por", 2'b00, {timeoutFlag, powerdownFlag});
    thru_core_model_inst.readReg(thru_pkg::REALTIME_TICK_CONTROL_ADDR, rd);
    `CHK("ctl reset", 8'h07, rd);
    for (int c = 0; c < 8; c++) begin
      thru_core_model_inst.writeReg(thru_pkg::REALTIME_TICK_CONTROL_ADDR, 8'(c));
      thru_core_model_inst.readReg(thru_pkg::REALTIME_TICK_CONTROL_ADDR, rd);
      `CHK("tick sel", 8'(c), rd);
    end
    thru_core_model_inst.writeReg(8'h0A, 8'h55);
    thru_core_model_inst.readReg(8'h0A, rd);
    `CHK("unmapped", 8'h00, rd);
    thru_core_model_inst.readReg(thru_pkg::REALTIME_TICK_CONTROL_ADDR, rd);
    `CHK("ctl kept", 8'h07, rd);
  endtask : tRegs

  task tTaps();
    thru_core_model_inst.setTick(2'h0);
    thru_core_model_inst.pulse(0);
    period(0, 4096);
    `CHK("timer src", 1'b1, timerRtcTick);
    period(1, 4096);
    period(2, 4);
    period(3, 512);
    @(posedge clk) dogOscTick <= 1'b0;
    waitFor(2, 20, n);
    `CHK("dog src stop", 1'b0, lcdClkTick);
    @(posedge clk) dogOscTick <= 1'b1;
    @(posedge clk) optLcdSel <= 3'h6;
    optBuzzSel <= 3'h0;
    period(2, 256);
    period(3, 4);
    @(posedge clk) optClkSrc <= thru_pkg::SRC_INSTR;
    optLcdSel <= 3'h0;
    period(2, 16);
    @(posedge clk) optClkSrc <= thru_pkg::SRC_RTC;
    period(2, 8);
    @(posedge clk) optClkSrc <= thru_pkg::SRC_DOG;
  endtask : tTaps

  task tWakes();
    enterHalt();
    @(posedge clk) thru_core_model_inst.irqFlags[0] <= 1'b1;
    waitResume(1'b1);
    @(posedge clk) thru_core_model_inst.irqFlags <= 4'h2;
    enterHalt();
    waitFor(2, 10, n);
    `CHK("lcd in halt", 1'b1, n < 10);
    @(posedge clk) portA <= 8'hFD;
    repeat (40) @(posedge clk);
    #1;
    `CHK("stay halted", 1'b1, coreStalled);
    @(posedge clk) portA <= 8'hFF;
    optWakeEn <= 8'h02;
    @(posedge clk) portA <= 8'hFD;
    waitResume(1'b0);
    @(posedge clk) portA <= 8'hFF;
    optClkSrc <= thru_pkg::SRC_INSTR;
    thru_core_model_inst.irqFlags <= 4'h0;
    thru_core_model_inst.stackFull <= 1'b1;
    enterHalt();
    waitFor(2, 20, n);
    `CHK("lcd instr halt", 1'b0, lcdClkTick);
    @(posedge clk) thru_core_model_inst.irqFlags[2] <= 1'b1;
    waitResume(1'b0);
    @(posedge clk) thru_core_model_inst.irqFlags <= 4'h0;
    thru_core_model_inst.stackFull <= 1'b0;
    optClkSrc <= thru_pkg::SRC_DOG;
  endtask : tWakes

  task tClears();
    thru_core_model_inst.pulse(1);
    #1;
    `CHK("single mode", 1'b1, powerdownFlag);
    thru_core_model_inst.pulse(0);
    #1;
    `CHK("pdf clear", 1'b0, powerdownFlag);
    @(posedge clk) optDualClear <= 1'b1;
    enterHalt();
    @(posedge clk) thru_core_model_inst.irqFlags[0] <= 1'b1;
    waitResume(1'b1);
    @(posedge clk) thru_core_model_inst.irqFlags <= 4'h0;
    thru_core_model_inst.pulse(0);
    thru_core_model_inst.pulse(1);
    #1;
    `CHK("half pair", 1'b1, powerdownFlag);
    thru_core_model_inst.pulse(2);
    #1;
    `CHK("pair done", 1'b0, powerdownFlag);
    @(posedge clk) optDualClear <= 1'b0;
  endtask : tClears

  task tDogs();
    thru_core_model_inst.writeReg(thru_pkg::REALTIME_TICK_CONTROL_ADDR, 8'h05);
    thru_core_model_inst.pulse(0);
    waitFor(4, 70000, n);
    `CHK("dog run", 1'b1, n >= 32768 && n <= 65540);
    @(posedge clk) #1;
    `CHK("flags run", 2'b10, {timeoutFlag, powerdownFlag});
    thru_core_model_inst.readReg(thru_pkg::REALTIME_TICK_CONTROL_ADDR, rd);
    `CHK("ctl chip", 8'h07, rd);
    thru_core_model_inst.writeReg(thru_pkg::REALTIME_TICK_CONTROL_ADDR, 8'h06);
    enterHalt();
    waitFor(5, 70000, n);
    `CHK("dog halt", 1'b1, n >= 32766 && n <= 65540);
    `CHK("no chip rst", 1'b0, chipResetOut);
    `CHK("flags warm", 2'b11, {timeoutFlag, powerdownFlag});
    waitResume(1'b0);
    thru_core_model_inst.readReg(thru_pkg::REALTIME_TICK_CONTROL_ADDR, rd);
    `CHK("ctl warm", 8'h06, rd);
  endtask : tDogs

  task tPin();
    enterHalt();
    @(posedge clk) chipInitPin_n <= 1'b0;
    @(posedge clk) #1;
    `CHK("pin rst", 1'b1, chipResetOut);
    @(posedge clk) chipInitPin_n <= 1'b1;
    @(posedge clk) #1;
    `CHK("flags pin", 2'b01, {timeoutFlag, powerdownFlag});
    waitFor(6, 1100, n);
    `CHK("pin wake", 1'b1, n < 1100);
    thru_core_model_inst.readReg(thru_pkg::REALTIME_TICK_CONTROL_ADDR, rd);
    `CHK("ctl pin", 8'h07, rd);
    @(posedge clk) chipInitPin_n <= 1'b0;
    @(posedge clk) chipInitPin_n <= 1'b1;
    @(posedge clk) #1;
    `CHK("flags kept", 2'b01, {timeoutFlag, powerdownFlag});
  endtask : tPin

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    chipInitPin_n = 1'b1;
    optDogEnable = 1'b1;
    optDualClear = 1'b0;
    dogOscTick = 1'b1;
    rtcOscTick = 1'b0;
    optClkSrc = thru_pkg::SRC_DOG;
    optTbSel = 2'h0;
    optLcdSel = 3'h0;
    optBuzzSel = 3'h7;
    optWakeEn = 8'h01;
    portA = 8'hFF;
    errTotal = 0;
    nCompared = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk) #1;
    tRegs();
    tTaps();
    tWakes();
    tClears();
    tDogs();
    tPin();
    endSim();
  end
endmodule : thru_core_test

//--- hw/thru_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - watchdog overflow while running: full chip reset, timeout flag set
// - watchdog overflow in power-down: warm reset of counter and stack only
// - watchdog cleared by reset pin low, clear instructions or power-down
// - option picks single clear or both of two clears before clearing
// - chain is 8-stage divider plus 7-bit prescaler from three sources
// - lcd tap fS/4 to fS/512, buzzer tap fS/4 to fS/512
// - periodic tick every fS/2^12 to fS/2^15, sets periodic flag
// - real-time period from bits 2..0 of register 09H, 2^8 to 2^15
// - each real-time timeout sets the real-time tick flag
// - real-time pulse also offered as timer/event counter clock
// - power-down stops system oscillator, slow oscillators keep running
// - power-down sets power-down flag, clears timeout flag and watchdog
// - lcd clocking continues in power-down on slow oscillator sources
// - wake on reset pin, interrupt, port A fall, or watchdog overflow
// - power-down flag cleared by power-up and watchdog clear
// - each port A pin enabled by option; resumes at next instruction
// - interrupt wake vectors only if enabled and stack not full
// - interrupt already pending before power-down cannot wake
// - 1024 system clock start-up delay after any wake-up
// - timeout and power-down flags encode the cause of reset
// - chip reset clears prescaler, divider, periodic and real-time ticks; watchdog restarts
// - watchdog period lies between fS/2^15 and fS/2^16
module thru_core (
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire logic                       chipInitPin_n,
  input  wire logic                       execDogClearSingle,
  input  wire logic                       execDogClearFirst,
  input  wire logic                       execDogClearSecond,
  input  wire logic                       execPowerDown,
  input  wire logic                       optDogEnable,
  input  wire logic                       optDualClear,
  input  wire logic [1:0]                 optClkSrc,
  input  wire logic [2:0]                 optLcdSel,
  input  wire logic [2:0]                 optBuzzSel,
  input  wire logic [1:0]                 optTbSel,
  input  wire logic [thru_pkg::PORT_W-1:0] optWakeEn,
  input  wire logic                       dogOscTick,
  input  wire logic                       rtcOscTick,
  input  wire logic [thru_pkg::PORT_W-1:0] portA,
  input  wire logic [thru_pkg::IRQ_N-1:0]  irqFlags,
  input  wire logic [thru_pkg::IRQ_N-1:0]  irqEnable,
  input  wire logic                       stackFull,
  input  wire logic                       regWrEn,
  input  wire logic [7:0]                 regAddr,
  input  wire logic [7:0]                 regWrData,
  output logic [7:0]                      regRdData,
  output logic                            chipResetOut,
  output logic                            warmResetOut,
  output logic                            timeoutFlag,
  output logic                            powerdownFlag,
  output logic                            sysOscRun,
  output logic                            coreStalled,
  output logic                            resumeGo,
  output logic                            wakeVector,
  output logic                            periodicTickPulse,
  output logic                            realtimeTickPulse,
  output logic                            timerRtcTick,
  output logic                            lcdClkTick,
  output logic                            buzzClkTick
);
  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  thru_pkg::thru_state_t st_reg;
  thru_pkg::thru_state_t st_next;
  logic                  instTick;
  logic                  srcTick;
  logic                  wdOvf;
  logic                  dogClear;
  logic                  newIrq;
  logic                  portFall;
  logic [2:0]            rtSel;

  function automatic logic tapHit(input logic [thru_pkg::CHAIN_W-1:0] c,
                                  input int k);
    logic [thru_pkg::CHAIN_W-1:0] m;
    m = thru_pkg::CHAIN_W'((32'h1 << k) - 32'h1);
    return (c & m) == m;
  endfunction : tapHit

  // ----------------------------------------------------------------
  // clock source and wake detection
  // ----------------------------------------------------------------
  assign rtSel    = st_reg.realtime_tick_control[thru_pkg::REALTIME_TICK_CONTROL_SEL_LSB +: thru_pkg::REALTIME_TICK_CONTROL_SEL_W];
  assign instTick = (st_reg.mode != thru_pkg::MODE_HALT) &&
                    (st_reg.instDiv == thru_pkg::INSTR_DIV_MAX);
  always_comb begin
    case (optClkSrc)
      thru_pkg::SRC_DOG:   srcTick = dogOscTick;
      thru_pkg::SRC_RTC:   srcTick = rtcOscTick;
      thru_pkg::SRC_INSTR: srcTick = instTick;
      default:             srcTick = 1'b0;
    endcase
  end
  assign wdOvf    = optDogEnable && srcTick && st_reg.wdStage &&
                    tapHit(st_reg.chain, thru_pkg::WD_TAP);
  assign newIrq   = |(irqFlags & ~st_reg.haltMask);
  assign portFall = |(st_reg.portPrev & ~portA & optWakeEn);
  assign dogClear = optDualClear ?
                    ((st_reg.seenFirst || execDogClearFirst) &&
                     (st_reg.seenSecond || execDogClearSecond) &&
                     (execDogClearFirst || execDogClearSecond)) :
                    execDogClearSingle;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    st_next.chipRst  = 1'b0;
    st_next.warmRst  = 1'b0;
    st_next.resumeGo = 1'b0;
    st_next.portPrev = portA;
    st_next.instDiv  = (st_reg.mode != thru_pkg::MODE_HALT) ?
                       st_reg.instDiv + 2'h1 : st_reg.instDiv;
    // taps, computed from the chain before it advances
    st_next.lcdTick  = srcTick &&
                       tapHit(st_reg.chain, thru_pkg::LCD_BASE + int'(optLcdSel));
    st_next.buzzTick = srcTick &&
                       tapHit(st_reg.chain, thru_pkg::BUZZ_BASE + int'(optBuzzSel));
    st_next.tbPulse  = srcTick &&
                       tapHit(st_reg.chain, thru_pkg::TB_BASE + int'(optTbSel));
    st_next.rtPulse  = srcTick &&
                       tapHit(st_reg.chain, thru_pkg::RT_BASE + int'(rtSel));
    if (srcTick) begin
      st_next.chain = st_reg.chain + thru_pkg::CHAIN_W'(1);
      if (tapHit(st_reg.chain, thru_pkg::WD_TAP)) begin
        st_next.wdStage = ~st_reg.wdStage;
      end
    end
    if (regWrEn && regAddr == thru_pkg::REALTIME_TICK_CONTROL_ADDR) begin
      st_next.realtime_tick_control = regWrData[thru_pkg::REALTIME_TICK_CONTROL_W-1:0];
    end
    st_next.rdData = (regAddr == thru_pkg::REALTIME_TICK_CONTROL_ADDR) ?
                     {2'h0, st_reg.realtime_tick_control} : 8'h00;
    // clear instructions, only honoured while executing
    if (st_reg.mode == thru_pkg::MODE_RUN) begin
      if (optDualClear) begin
        st_next.seenFirst  = st_reg.seenFirst || execDogClearFirst;
        st_next.seenSecond = st_reg.seenSecond || execDogClearSecond;
      end
      if (dogClear) begin
        st_next.wdStage       = 1'b0;
        st_next.seenFirst     = 1'b0;
        st_next.seenSecond    = 1'b0;
        st_next.powerdownFlag = 1'b0;
      end
    end
    case (st_reg.mode)
      thru_pkg::MODE_RUN: begin
        if (st_reg.pinWasHalt) begin
          st_next.pinWasHalt = 1'b0;
          st_next.startCnt   = '0;
          st_next.mode       = thru_pkg::MODE_WAKE;
        end else if (wdOvf) begin
          st_next.chipRst     = 1'b1;
          st_next.timeoutFlag = 1'b1;
          st_next.chain       = '0;
          st_next.wdStage     = 1'b0;
          st_next.seenFirst   = 1'b0;
          st_next.seenSecond  = 1'b0;
          st_next.tbPulse     = 1'b0;
          st_next.rtPulse     = 1'b0;
          st_next.realtime_tick_control        = thru_pkg::REALTIME_TICK_CONTROL_RESET;
        end else if (execPowerDown) begin
          st_next.mode          = thru_pkg::MODE_HALT;
          st_next.powerdownFlag = 1'b1;
          st_next.timeoutFlag   = 1'b0;
          st_next.wdStage       = 1'b0;
          st_next.seenFirst     = 1'b0;
          st_next.seenSecond    = 1'b0;
          st_next.haltMask      = irqFlags;
        end
      end
      thru_pkg::MODE_HALT: begin
        if (wdOvf) begin
          st_next.warmRst     = 1'b1;
          st_next.timeoutFlag = 1'b1;
          st_next.wdStage     = 1'b0;
          st_next.wakeVector  = 1'b0;
          st_next.startCnt    = '0;
          st_next.mode        = thru_pkg::MODE_WAKE;
        end else if (newIrq || portFall) begin
          st_next.wakeVector = newIrq && !stackFull &&
                               |(irqFlags & ~st_reg.haltMask & irqEnable);
          st_next.startCnt   = '0;
          st_next.mode       = thru_pkg::MODE_WAKE;
        end
      end
      thru_pkg::MODE_WAKE: begin
        st_next.startCnt = st_reg.startCnt + thru_pkg::STARTUP_W'(1);
        if (st_reg.startCnt ==
            thru_pkg::STARTUP_W'(thru_pkg::STARTUP_CYCLES - 1)) begin
          st_next.resumeGo = 1'b1;
          st_next.mode     = thru_pkg::MODE_RUN;
        end
      end
      default: st_next.mode = thru_pkg::MODE_RUN;
    endcase
    if (st_reg.mode == thru_pkg::MODE_RUN && st_next.resumeGo == 1'b0 &&
        st_reg.mode == st_next.mode) begin
      st_next.wakeVector = 1'b0;
    end
    // reset pin held low: full initialisation; flags kept while running, otherwise timeout flag 0 and power-down flag 1
    if (!chipInitPin_n) begin
      st_next.pinWasHalt = st_reg.pinWasHalt ||
                           st_reg.mode != thru_pkg::MODE_RUN;
      st_next.mode       = thru_pkg::MODE_RUN;
      st_next.chipRst    = 1'b1;
      st_next.warmRst    = 1'b0;
      st_next.resumeGo   = 1'b0;
      st_next.wakeVector = 1'b0;
      st_next.chain      = '0;
      st_next.wdStage    = 1'b0;
      st_next.seenFirst  = 1'b0;
      st_next.seenSecond = 1'b0;
      st_next.tbPulse    = 1'b0;
      st_next.rtPulse    = 1'b0;
      st_next.realtime_tick_control       = thru_pkg::REALTIME_TICK_CONTROL_RESET;
      if (st_reg.mode != thru_pkg::MODE_RUN) begin
        st_next.timeoutFlag   = 1'b0;
        st_next.powerdownFlag = 1'b1;
      end else begin
        st_next.timeoutFlag   = st_reg.timeoutFlag;
        st_next.powerdownFlag = st_reg.powerdownFlag;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg               <= '0;
      st_reg.mode          <= thru_pkg::MODE_RUN;
      st_reg.realtime_tick_control          <= thru_pkg::REALTIME_TICK_CONTROL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRdData         = st_reg.rdData;
  assign chipResetOut      = st_reg.chipRst;
  assign warmResetOut      = st_reg.warmRst;
  assign timeoutFlag       = st_reg.timeoutFlag;
  assign powerdownFlag     = st_reg.powerdownFlag;
  assign sysOscRun         = st_reg.mode != thru_pkg::MODE_HALT;
  assign coreStalled       = st_reg.mode != thru_pkg::MODE_RUN;
  assign resumeGo          = st_reg.resumeGo;
  assign wakeVector        = st_reg.wakeVector;
  assign periodicTickPulse = st_reg.tbPulse;
  assign realtimeTickPulse = st_reg.rtPulse;
  assign timerRtcTick      = st_reg.rtPulse;
  assign lcdClkTick        = st_reg.lcdTick;
  assign buzzClkTick       = st_reg.buzzTick;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_halt_wdovf;
    st_reg.mode == thru_pkg::MODE_HALT && wdOvf && chipInitPin_n;
  endsequence
  sequence s_warm_done;
    warmResetOut && !chipResetOut && timeoutFlag && powerdownFlag;
  endsequence
  sequence s_start_end;
    st_reg.mode == thru_pkg::MODE_WAKE && st_reg.startCnt == 10'h3FF;
  endsequence

  property p_wd_run;
    @(posedge clk) disable iff (!arst_n)
    st_reg.mode == thru_pkg::MODE_RUN && !st_reg.pinWasHalt && wdOvf &&
    chipInitPin_n |=> chipResetOut && timeoutFlag && st_reg.chain == '0;
  endproperty
  a_wd_run: assert property (p_wd_run)
    else $error("watchdog overflow gave no chip reset");

  property p_wd_halt;
    @(posedge clk) disable iff (!arst_n)
    s_halt_wdovf |=> s_warm_done ##1 st_reg.mode == thru_pkg::MODE_WAKE;
  endproperty
  a_wd_halt: assert property (p_wd_halt)
    else $error("watchdog overflow in power-down gave no warm reset");

  property p_pd_entry;
    @(posedge clk) disable iff (!arst_n)
    st_reg.mode == thru_pkg::MODE_RUN && execPowerDown && !wdOvf &&
    !st_reg.pinWasHalt && chipInitPin_n |=>
    powerdownFlag && !timeoutFlag && !st_reg.wdStage && !sysOscRun;
  endproperty
  a_pd_entry: assert property (p_pd_entry)
    else $error("power-down entry flags wrong");

  property p_single_clear;
    @(posedge clk) disable iff (!arst_n)
    st_reg.mode == thru_pkg::MODE_RUN && !optDualClear &&
    execDogClearSingle && chipInitPin_n && !execPowerDown && !wdOvf
    |=> !st_reg.wdStage && !powerdownFlag;
  endproperty
  a_single_clear: assert property (p_single_clear)
    else $error("single clear did not clear watchdog");

  property p_dual_half;
    @(posedge clk) disable iff (!arst_n)
    st_reg.mode == thru_pkg::MODE_RUN && optDualClear && powerdownFlag &&
    !st_reg.seenSecond && !execDogClearSecond && chipInitPin_n
    |=> powerdownFlag;
  endproperty
  a_dual_half: assert property (p_dual_half)
    else $error("half of a dual clear acted");

  property p_startup;
    @(posedge clk) disable iff (!arst_n)
    s_start_end and chipInitPin_n |=> resumeGo && !coreStalled;
  endproperty
  a_startup: assert property (p_startup)
    else $error("start-up delay did not end at 1024 cycles");

  property p_startup_begin;
    @(posedge clk) disable iff (!arst_n)
    $rose(st_reg.mode == thru_pkg::MODE_WAKE) |-> st_reg.startCnt == '0;
  endproperty
  a_startup_begin: assert property (p_startup_begin)
    else $error("start-up count did not start at zero");

  property p_old_irq;
    @(posedge clk) disable iff (!arst_n)
    st_reg.mode == thru_pkg::MODE_HALT && !newIrq && !portFall &&
    !wdOvf && chipInitPin_n |=> st_reg.mode == thru_pkg::MODE_HALT;
  endproperty
  a_old_irq: assert property (p_old_irq)
    else $error("left power-down without a wake source");

  property p_realtime_tick_control_reset;
    @(posedge clk) disable iff (!arst_n)
    chipResetOut |-> st_reg.realtime_tick_control == thru_pkg::REALTIME_TICK_CONTROL_RESET;
  endproperty
  a_realtime_tick_control_reset: assert property (p_realtime_tick_control_reset)
    else $error("real-time control not reset on chip reset");

  property p_instr_halt;
    @(posedge clk) disable iff (!arst_n)
    st_reg.mode == thru_pkg::MODE_HALT && optClkSrc == thru_pkg::SRC_INSTR
    && chipInitPin_n |=> $stable(st_reg.chain);
  endproperty
  a_instr_halt: assert property (p_instr_halt)
    else $error("instruction clock chain ran in power-down");
endmodule : thru_core

//--- hw/thru_pkg.sv
package thru_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REALTIME_TICK_CONTROL_ADDR    = 8'h09;
  localparam int         REALTIME_TICK_CONTROL_W       = 6;
  localparam logic [5:0] REALTIME_TICK_CONTROL_RESET   = 6'h07;
  localparam int         REALTIME_TICK_CONTROL_SEL_LSB = 0;
  localparam int         REALTIME_TICK_CONTROL_SEL_W   = 3;

  // ----------------------------------------------------------------
  // timing chain
  // ----------------------------------------------------------------
  localparam int         CHAIN_W      = 15;
  localparam int         LCD_BASE     = 2;
  localparam int         BUZZ_BASE    = 2;
  localparam int         TB_BASE      = 12;
  localparam int         RT_BASE      = 8;
  localparam int         WD_TAP       = 15;
  localparam logic [1:0] INSTR_DIV_MAX = 2'h3;
  localparam logic [1:0] SRC_DOG      = 2'h0;
  localparam logic [1:0] SRC_RTC      = 2'h1;
  localparam logic [1:0] SRC_INSTR    = 2'h2;

  // ----------------------------------------------------------------
  // start-up delay, in system clock periods
  // ----------------------------------------------------------------
  localparam int         STARTUP_CYCLES = 1024;
  localparam int         STARTUP_W      = 10;
  localparam int         IRQ_N          = 4;
  localparam int         PORT_W         = 8;

  typedef enum logic [1:0] {
    MODE_RUN  = 2'h0,
    MODE_HALT = 2'h1,
    MODE_WAKE = 2'h3
  } thru_mode_t;

  typedef struct packed {
    thru_mode_t           mode;
    logic [CHAIN_W-1:0]   chain;
    logic                 wdStage;
    logic [1:0]           instDiv;
    logic                 seenFirst;
    logic                 seenSecond;
    logic                 timeoutFlag;
    logic                 powerdownFlag;
    logic [REALTIME_TICK_CONTROL_W-1:0]    realtime_tick_control;
    logic [IRQ_N-1:0]     haltMask;
    logic [PORT_W-1:0]    portPrev;
    logic [STARTUP_W-1:0] startCnt;
    logic                 pinWasHalt;
    logic                 wakeVector;
    logic                 chipRst;
    logic                 warmRst;
    logic                 resumeGo;
    logic                 tbPulse;
    logic                 rtPulse;
    logic                 lcdTick;
    logic                 buzzTick;
    logic [7:0]           rdData;
  } thru_state_t;
endpackage : thru_pkg
